// >>> include/ulp_params.svh
`ifndef ULP_PARAMS_SVH
`define ULP_PARAMS_SVH

// Register offsets of the controller's own APB window.
`define ULP_OFS_CMD 8'h00
`define ULP_OFS_STAT 8'h04
`define ULP_OFS_RDAT 8'h08
`define ULP_OFS_EVT 8'h0C
`define ULP_OFS_SETUP 8'h10

// Command register fields.
`define ULP_CMD_WD 7:0
`define ULP_CMD_AD 15:8
`define ULP_CMD_RD 16
`define ULP_CMD_EXT 17

// Setup register fields.
`define ULP_SU_GO 0
`define ULP_SU_ROLE 2:1
`define ULP_SU_FEXT 3
`define ULP_SU_FPOL 4
`define ULP_SU_RST 5
`define ULP_SU_W 6

// Sticky event bits, write one to clear.
`define ULP_EV_VB 0
`define ULP_EV_DC 1
`define ULP_EV_DROP 2
`define ULP_EV_ABT 3
`define ULP_EV_DONE 4
`define ULP_EV_W 5

// Transmit command codes and the extended-address escape.
`define ULP_TX_REGW 2'b10
`define ULP_TX_REGR 2'b11
`define ULP_EXT_ESC 6'h2F

// Receive command layout and codes.
`define ULP_RX_LS 1:0
`define ULP_RX_VB 3:2
`define ULP_RX_EV 5:4
`define ULP_RX_ALT 7
`define ULP_RXE_NONE 2'b00
`define ULP_RXE_ACT 2'b01
`define ULP_RXE_ERR 2'b11
`define ULP_RXE_DISC 2'b10
`define ULP_LS_DP 2'b01
`define ULP_LS_DM 2'b10
`define ULP_SPD_LS 2'b01
`define ULP_SPD_FS 2'b10

// Transceiver register addresses and bits used by the setup script.
`define ULP_A_FUNC 8'h04
`define ULP_A_IFC 8'h07
`define ULP_A_OTG 8'h0A
`define ULP_A_IER 8'h0D
`define ULP_A_IEF 8'h10
`define ULP_IE_DISC 0
`define ULP_IE_AVLD 1
`define ULP_IE_SVLD 2
`define ULP_IE_SEND 3
`define ULP_IF_COMPL 5
`define ULP_IF_PASS 6
`define ULP_OTG_DPPD 1
`define ULP_OTG_DMPD 2
`define ULP_OTG_EXTIND 7
`define ULP_FC_CHIRP_RST 8'h10

// Script steps.
`define ULP_STEP_IER 3'h0
`define ULP_STEP_IEF 3'h1
`define ULP_STEP_IFC 3'h2
`define ULP_STEP_OTG 3'h3
`define ULP_STEP_RST 3'h4

`endif

// >>> include/ulp_pkg.sv
package ulp_pkg;
	typedef enum logic [3:0] {
		s_idle, s_cmd, s_ext, s_wdata, s_stp, s_rturn, s_rdata, s_rend, s_abort
	} ulp_acc_t;
	typedef enum logic [1:0] {role_host, role_periph, role_adev, role_bdev} ulp_role_t;
	typedef struct packed {
		ulp_acc_t st;
		logic clk_prev;
		logic [7:0] dout;
		logic oe;
		logic stp;
		logic req;
		logic busy;
		logic rd;
		logic ext;
		logic [7:0] addr;
		logic [7:0] wd;
		logic [7:0] rdata;
		logic scr;
		logic [2:0] step;
		logic [5:0] setup;
		logic chirp;
		logic [4:0] ev;
		logic [7:0] retries;
	} ulp_link_t;
	typedef struct packed {
		logic dir_prev;
		logic [1:0] ls;
		logic [1:0] vb;
		logic act;
		logic disc;
		logic alt;
		logic [1:0] spd;
		logic hs;
		logic [7:0] rx_byte;
		logic bval;
		logic vchg;
		logic dchg;
		logic err;
	} ulp_dec_t;
endpackage : ulp_pkg

// >>> tb/ulp_xcvr_model.sv
`include "ulp_params.svh"

module ulp_xcvr_model
	import ulp_pkg::*;
	(
	input wire logic [7:0] i_ldata,
	input wire logic i_loe,
	input wire logic i_stp,
	output logic o_uclk,
	output logic o_dir,
	output logic o_nxt,
	output logic [7:0] o_bus
	);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] regs [0:63];
	logic [7:0] pd, last, cmd;
	logic [5:0] adr;
	logic [2:0] ph;
	logic [1:0] ls, vb;
	logic dsc, abort_req;
	// A released bus shows a changing pattern so a stale byte is never mistaken for data.
	assign o_bus = o_dir ? pd : (i_loe ? i_ldata : ~last);
	function automatic logic [7:0] rxb(input logic [1:0] ev);
		return {2'b00, ev, vb, ls};
	endfunction : rxb
	function automatic logic [1:0] evd();
		logic pdn;
		pdn = regs[`ULP_A_OTG][`ULP_OTG_DPPD] && regs[`ULP_A_OTG][`ULP_OTG_DMPD];
		return (dsc && pdn) ? 2'b10 : 2'b00;
	endfunction : evd
	initial begin
		for (int i = 0; i < 64; i++) regs[i] = 8'h00;
		{o_dir, o_nxt, dsc, abort_req} = 4'h0;
		{pd, last, cmd, adr, ph, ls, vb} = 37'h0;
		o_uclk = 1'b0;
		#7;
		forever #24 o_uclk = ~o_uclk;
	end
	always @(posedge o_uclk) begin
		last <= o_bus;
		case (ph)
		3'd0: if (i_loe && i_ldata[7] && abort_req) begin
			abort_req <= 1'b0;
			o_dir <= 1'b1;
			pd <= rxb(evd());
			ph <= 3'd7;
		end else if (i_loe && i_ldata[7]) begin
			cmd <= i_ldata;
			adr <= i_ldata[5:0];
			o_nxt <= 1'b1;
			ph <= (i_ldata[5:0] == `ULP_EXT_ESC) ? 3'd1 : (i_ldata[6] ? 3'd4 : 3'd2);
		end
		3'd1: begin
			adr <= i_ldata[5:0];
			ph <= cmd[6] ? 3'd4 : 3'd2;
		end
		3'd2: begin
			regs[adr] <= i_ldata;
			ph <= 3'd3;
		end
		3'd3: if (i_stp) begin
			o_nxt <= 1'b0;
			ph <= 3'd0;
		end
		3'd4: begin
			o_nxt <= 1'b0;
			o_dir <= 1'b1;
			pd <= regs[adr];
			ph <= 3'd5;
		end
		3'd5: ph <= 3'd6;
		3'd6: begin
			o_dir <= 1'b0;
			ph <= 3'd0;
		end
		default: ph <= 3'd6;
		endcase
	end
	task automatic rxcmd(input logic [1:0] ev);
		@(posedge o_uclk);
		o_dir <= 1'b1;
		o_nxt <= 1'b0;
		pd <= rxb(ev);
		@(posedge o_uclk);
		@(posedge o_uclk);
		o_dir <= 1'b0;
	endtask : rxcmd
	task automatic vbus(input logic [1:0] v);
		logic [7:0] en;
		en = (v > vb) ? regs[`ULP_A_IER] : regs[`ULP_A_IEF];
		vb = v;
		if (en[3:1] != 3'b000) rxcmd(evd());
	endtask : vbus
	task automatic line(input logic [1:0] l);
		ls = l;
		rxcmd(evd());
	endtask : line
	task automatic disc(input logic d);
		dsc = d;
		rxcmd(evd());
	endtask : disc
	task automatic pkt(input int n, input logic m2, input logic er, input logic [31:0] w);
		@(posedge o_uclk);
		o_dir <= 1'b1;
		o_nxt <= !m2;
		pd <= rxb(2'b01);
		if (m2) @(posedge o_uclk);
		for (int i = 0; i < n; i++) begin
			@(posedge o_uclk);
			o_nxt <= 1'b1;
			pd <= w[8*i +: 8];
		end
		@(posedge o_uclk);
		o_nxt <= 1'b0;
		pd <= rxb(er ? 2'b11 : (m2 ? 2'b00 : 2'b01));
		@(posedge o_uclk);
		o_dir <= 1'b0;
	endtask : pkt
endmodule : ulp_xcvr_model

// >>> tb/ulpi_rxcmd_event_reporting_bench.sv
`include "ulp_params.svh"

module ulpi_rxcmd_event_reporting_bench
	import ulp_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr;
	logic uclk, dir, nxt, loe, stp, rx_valid, rx_active, ce;
	logic [7:0] paddr, bus, ldata, rx_byte;
	logic [31:0] pwdata, prdata, q, r1;
	logic [2:0] e3;
	logic [32:0] exp_q[$], msk_q[$];
	logic [7:0] rx_q[$];
	int err_total, num_checks;
	int cyc = 0;
	ulp_host_link i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_ulpi_clk(uclk),
		.i_ulpi_dir(dir), .i_ulpi_nxt(nxt), .i_ulpi_data(bus), .o_ulpi_data(ldata),
		.o_ulpi_data_oe(loe), .o_ulpi_stp(stp), .o_rx_byte(rx_byte), .o_rx_valid(rx_valid),
		.o_rx_active(rx_active));
	ulp_xcvr_model i_xcvr (.i_ldata(ldata), .i_loe(loe), .i_stp(stp), .o_uclk(uclk),
		.o_dir(dir), .o_nxt(nxt), .o_bus(bus));
	initial i_clk = 1'b0;
	always #2.5 i_clk = ~i_clk;
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		// One frozen cycle in eleven stretches bus waits without ever missing a link edge.
		ce <= (cyc % 11) != 10;
		if (cyc == 60000) begin
			err_total++;
			conclude();
		end else begin
			if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
				if (msk_q[0] != 33'h0) chk("apb read", exp_q[0], {pslverr, prdata} & msk_q[0]);
				void'(exp_q.pop_front());
				void'(msk_q.pop_front());
			end
			// A byte pulse stands until the next enabled edge, so only that edge counts it.
			if (rx_valid === 1'b1 && ce === 1'b1) begin
				chk("rx byte", {25'h0, rx_q[0]}, {25'h0, rx_byte});
				chk("rx active", 33'h1, {32'h0, rx_active});
				void'(rx_q.pop_front());
			end
		end
	end
	// Every read leaves a note; a zero mask marks a poll whose value is judged elsewhere.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		if (!w) begin
			exp_q.push_back(e & m);
			msk_q.push_back(m);
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge i_clk);
		penable <= 1'b1;
		do begin
			@(posedge i_clk);
		end while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_clk);
	endtask : apb
	task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0, 33'h0, 33'h0);
			n++;
		end while ((q & m) !== v && n < 400);
		chk(nm, {1'b0, v}, {1'b0, q & m});
	endtask : poll
	task automatic acc(input logic rd, input logic ex, input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, `ULP_OFS_CMD, {14'h0000, ex, rd, a, d}, 33'h0, 33'h0);
		poll("busy", `ULP_OFS_STAT, 32'h0000_0001, 32'h0000_0000);
	endtask : acc
	initial begin
		{i_rst_n, psel, penable, pwrite, paddr, pwdata} = 44'h0;
		{err_total, num_checks} = 64'h0;
		r1 = $urandom(32'hacb9f58d);
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		apb(1'b0, 8'h14, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
		$display("test unmapped done");
		for (int r = 3; r >= 0; r--) begin
			q = {26'h0, r == 0, r1[0], r == 0, r[1:0], 1'b1};
			apb(1'b1, `ULP_OFS_SETUP, q, 33'h0, 33'h0);
			poll("script", `ULP_OFS_STAT, 32'h0000_0001, 32'h0000_0000);
			e3 = (r == 0) ? 3'b001 : (r == 1) ? 3'b010 : (r == 2) ? 3'b011 : 3'b110;
			chk("rise en", {30'h0, e3}, 33'(i_xcvr.regs[`ULP_A_IER][3:1]));
			chk("fall en", {30'h0, e3}, 33'(i_xcvr.regs[`ULP_A_IEF][3:1]));
		end
		chk("disc en", 33'h3,
			33'({i_xcvr.regs[`ULP_A_IER][0], i_xcvr.regs[`ULP_A_IEF][0]}));
		chk("iface", {26'h0, 1'b1, r1[0], 5'h0}, 33'(i_xcvr.regs[`ULP_A_IFC] & 8'h60));
		chk("dual role", 33'h86, 33'(i_xcvr.regs[`ULP_A_OTG] & 8'h86));
		chk("func", 33'h10, {25'h0, i_xcvr.regs[`ULP_A_FUNC]});
		apb(1'b0, `ULP_OFS_STAT, 32'h0, 33'h800, 33'h800);
		i_xcvr.line(2'b01);
		poll("chirp", `ULP_OFS_STAT, 32'h0000_0700, 32'h0000_0400);
		i_xcvr.line(2'b10);
		poll("chirp", `ULP_OFS_STAT, 32'h0000_0700, 32'h0000_0000);
		apb(1'b1, `ULP_OFS_SETUP, 32'h0, 33'h0, 33'h0);
		$display("test setup done");
		i_xcvr.vbus(2'b11);
		poll("supply", `ULP_OFS_STAT, 32'h0000_0030, 32'h0000_0030);
		apb(1'b0, `ULP_OFS_EVT, 32'h0, 33'h1, 33'h1);
		apb(1'b1, `ULP_OFS_EVT, 32'h0000_001F, 33'h0, 33'h0);
		i_xcvr.vbus(2'b01);
		poll("supply", `ULP_OFS_STAT, 32'h0000_0030, 32'h0000_0010);
		i_xcvr.line(2'b10);
		poll("line", `ULP_OFS_STAT, 32'h0000_030C, 32'h0000_0108);
		i_xcvr.line(2'b01);
		poll("line", `ULP_OFS_STAT, 32'h0000_030C, 32'h0000_0204);
		i_xcvr.disc(1'b1);
		poll("disc", `ULP_OFS_STAT, 32'h0000_0040, 32'h0000_0040);
		apb(1'b0, `ULP_OFS_EVT, 32'h0, 33'h2, 33'h2);
		i_xcvr.disc(1'b0);
		poll("disc", `ULP_OFS_STAT, 32'h0000_0040, 32'h0000_0000);
		$display("test events done");
		for (int k = 0; k < 3; k++) begin
			r1 = $urandom();
			for (int i = 0; i < 3; i++) rx_q.push_back(r1[8*i +: 8]);
			i_xcvr.pkt(3, k[0], k == 2, r1);
			poll("rx end", `ULP_OFS_STAT, 32'h0000_0002, 32'h0000_0000);
		end
		apb(1'b0, `ULP_OFS_EVT, 32'h0, 33'h4, 33'h4);
		$display("test receive done");
		r1 = $urandom();
		acc(1'b0, 1'b0, 8'h16, r1[7:0]);
		acc(1'b1, 1'b0, 8'h16, 8'h00);
		apb(1'b0, `ULP_OFS_RDAT, 32'h0, {25'h0, r1[7:0]}, 33'hFF);
		acc(1'b0, 1'b1, 8'h35, r1[15:8]);
		acc(1'b1, 1'b1, 8'h35, 8'h00);
		apb(1'b0, `ULP_OFS_RDAT, 32'h0, {25'h0, r1[15:8]}, 33'hFF);
		i_xcvr.abort_req = 1'b1;
		acc(1'b1, 1'b0, 8'h16, 8'h00);
		apb(1'b0, `ULP_OFS_RDAT, 32'h0, {25'h0, r1[7:0]}, 33'hFF);
		poll("retries", `ULP_OFS_STAT, 32'h000F_F000, 32'h0000_1000);
		i_xcvr.abort_req = 1'b1;
		acc(1'b0, 1'b0, 8'h17, r1[23:16]);
		chk("reg write", {25'h0, r1[23:16]}, {25'h0, i_xcvr.regs[8'h17]});
		apb(1'b0, `ULP_OFS_EVT, 32'h0, 33'h8, 33'h8);
		$display("test access done");
		chk("rx left", 33'h0, 33'(rx_q.size()));
		conclude();
	end
endmodule : ulpi_rxcmd_event_reporting_bench

// >>> verilog/ulp_host_link.sv
// Design decisions made here: the APB slave port and the register addresses.
`include "ulp_params.svh"

module ulp_host_link
	import ulp_pkg::*;
	(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_ulpi_clk,
	input wire logic i_ulpi_dir,
	input wire logic i_ulpi_nxt,
	input wire logic [7:0] i_ulpi_data,
	output logic [7:0] o_ulpi_data,
	output logic o_ulpi_data_oe,
	output logic o_ulpi_stp,
	output logic [7:0] o_rx_byte,
	output logic o_rx_valid,
	output logic o_rx_active
	);

	ulp_link_t r_ff;
	ulp_link_t nxt_r;
	logic [10:0] sync_q;
	logic clk_s;
	logic dir_s;
	logic nxt_s;
	logic [7:0] din;
	logic tick;
	logic own;
	logic host;
	logic [1:0] ls;
	logic [1:0] vb;
	logic disc;
	logic alt;
	logic [1:0] spd;
	logic hs;
	logic vchg;
	logic dchg;
	logic rx_err;
	logic apb_acc;
	logic apb_wr;
	logic mapped;

	ulp_sync #(.W(11)) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_d({i_ulpi_clk, i_ulpi_dir, i_ulpi_nxt, i_ulpi_data}),
		.o_q(sync_q)
	);

	assign clk_s = sync_q[10];
	assign dir_s = sync_q[9];
	assign nxt_s = sync_q[8];
	assign din = sync_q[7:0];
	// All pin activity is stepped on the detected rising edge of the link clock.
	assign tick = clk_s & ~r_ff.clk_prev;
	assign own = (r_ff.st == s_rturn) || (r_ff.st == s_rdata) || (r_ff.st == s_rend);
	assign host = (ulp_role_t'(r_ff.setup[`ULP_SU_ROLE]) == role_host)
		|| (ulp_role_t'(r_ff.setup[`ULP_SU_ROLE]) == role_adev);

	ulp_rxcmd_dec u_dec (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_tick(tick),
		.i_dir(dir_s),
		.i_nxt(nxt_s),
		.i_data(din),
		.i_own(own),
		.i_host(host),
		.i_chirp(r_ff.chirp),
		.o_linestate(ls),
		.o_vbus(vb),
		.o_rx_active(o_rx_active),
		.o_disc(disc),
		.o_alt(alt),
		.o_speed(spd),
		.o_chirp_hs(hs),
		.o_rx_byte(o_rx_byte),
		.o_rx_valid(o_rx_valid),
		.o_vbus_chg(vchg),
		.o_disc_chg(dchg),
		.o_err(rx_err)
	);

	// One setup step: transceiver address in the upper byte, value in the lower.
	function automatic logic [15:0] script_word(input logic [2:0] step, input logic [5:0] su);
		logic [7:0] ie;
		logic [7:0] ifc;
		logic [7:0] otg;
		ulp_role_t role;
		role = ulp_role_t'(su[`ULP_SU_ROLE]);
		ie = 8'h00;
		ifc = 8'h00;
		otg = 8'h00;
		case (role)
			role_host: begin
				ie[`ULP_IE_AVLD] = 1'b1;
				ie[`ULP_IE_DISC] = 1'b1;
			end
			role_periph: begin
				ie[`ULP_IE_SVLD] = 1'b1;
			end
			role_adev: begin
				ie[`ULP_IE_AVLD] = 1'b1;
				ie[`ULP_IE_SVLD] = 1'b1;
				ie[`ULP_IE_DISC] = 1'b1;
			end
			default: begin
				ie[`ULP_IE_SVLD] = 1'b1;
				ie[`ULP_IE_SEND] = 1'b1;
			end
		endcase
		// A heavy A-device must set the fault bit too, so it shares the host path.
		if (su[`ULP_SU_FEXT]) begin
			ifc[`ULP_IF_COMPL] = su[`ULP_SU_FPOL];
			ifc[`ULP_IF_PASS] = 1'b1;
			otg[`ULP_OTG_EXTIND] = 1'b1;
		end
		if (role == role_host || role == role_adev) begin
			// Disconnect reports mean nothing without both pulldowns.
			otg[`ULP_OTG_DPPD] = 1'b1;
			otg[`ULP_OTG_DMPD] = 1'b1;
		end
		case (step)
			`ULP_STEP_IER: script_word = {`ULP_A_IER, ie};
			`ULP_STEP_IEF: script_word = {`ULP_A_IEF, ie};
			`ULP_STEP_IFC: script_word = {`ULP_A_IFC, ifc};
			`ULP_STEP_OTG: script_word = {`ULP_A_OTG, otg};
			default: script_word = {`ULP_A_FUNC, `ULP_FC_CHIRP_RST};
		endcase
	endfunction : script_word

	assign apb_acc = i_psel & i_penable;
	assign apb_wr = apb_acc & i_pwrite;
	assign mapped = (i_paddr == `ULP_OFS_CMD) || (i_paddr == `ULP_OFS_STAT)
		|| (i_paddr == `ULP_OFS_RDAT) || (i_paddr == `ULP_OFS_EVT)
		|| (i_paddr == `ULP_OFS_SETUP);
	// A frozen cycle takes no transfer, so the access is stretched instead of lost.
	assign o_pready = i_ce;
	assign o_pslverr = apb_acc & ~mapped;

	always_comb begin
		case (i_paddr)
			`ULP_OFS_STAT: o_prdata = {12'h000, r_ff.retries, r_ff.chirp, hs, spd, alt, disc,
				vb, ls, o_rx_active, r_ff.busy};
			`ULP_OFS_RDAT: o_prdata = {16'h0000, o_rx_byte, r_ff.rdata};
			`ULP_OFS_EVT: o_prdata = {27'h000_0000, r_ff.ev};
			`ULP_OFS_SETUP: o_prdata = {26'h000_0000, r_ff.setup};
			default: o_prdata = 32'h0000_0000;
		endcase
	end

	always_comb begin
		logic fin;
		logic abort;
		logic [2:0] last;
		logic [15:0] sw;
		fin = 1'b0;
		abort = 1'b0;
		last = r_ff.setup[`ULP_SU_RST] ? `ULP_STEP_RST : `ULP_STEP_OTG;
		sw = script_word(r_ff.step + 3'h1, r_ff.setup);
		nxt_r = r_ff;
		nxt_r.clk_prev = clk_s;
		if (apb_wr && i_paddr == `ULP_OFS_EVT) begin
			nxt_r.ev = r_ff.ev & ~i_pwdata[`ULP_EV_W-1:0];
		end
		if (apb_wr && i_paddr == `ULP_OFS_CMD && !r_ff.busy) begin
			nxt_r.wd = i_pwdata[`ULP_CMD_WD];
			nxt_r.addr = i_pwdata[`ULP_CMD_AD];
			nxt_r.rd = i_pwdata[`ULP_CMD_RD];
			nxt_r.ext = i_pwdata[`ULP_CMD_EXT];
			nxt_r.req = 1'b1;
			nxt_r.busy = 1'b1;
		end
		if (apb_wr && i_paddr == `ULP_OFS_SETUP) begin
			nxt_r.setup = {i_pwdata[`ULP_SU_W-1:1], 1'b0};
			nxt_r.chirp = 1'b0;
			if (i_pwdata[`ULP_SU_GO] && !r_ff.busy) begin
				{nxt_r.addr, nxt_r.wd} = script_word(`ULP_STEP_IER, i_pwdata[`ULP_SU_W-1:0]);
				nxt_r.step = `ULP_STEP_IER;
				nxt_r.rd = 1'b0;
				nxt_r.ext = 1'b0;
				nxt_r.scr = 1'b1;
				nxt_r.req = 1'b1;
				nxt_r.busy = 1'b1;
			end
		end
		if (tick) begin
			case (r_ff.st)
				s_idle: begin
					nxt_r.stp = 1'b0;
					nxt_r.dout = 8'h00;
					nxt_r.oe = ~dir_s;
					if (r_ff.req && !dir_s) begin
						nxt_r.dout = {r_ff.rd ? `ULP_TX_REGR : `ULP_TX_REGW,
							r_ff.ext ? `ULP_EXT_ESC : r_ff.addr[5:0]};
						nxt_r.oe = 1'b1;
						nxt_r.st = s_cmd;
					end
				end
				s_cmd, s_ext: begin
					if (dir_s) begin
						abort = 1'b1;
					end else if (nxt_s && r_ff.st == s_cmd && r_ff.ext) begin
						nxt_r.dout = r_ff.addr;
						nxt_r.st = s_ext;
					end else if (nxt_s && r_ff.rd) begin
						nxt_r.dout = 8'h00;
						nxt_r.oe = 1'b0;
						nxt_r.st = s_rturn;
					end else if (nxt_s) begin
						nxt_r.dout = r_ff.wd;
						nxt_r.st = s_wdata;
					end
				end
				s_wdata: begin
					if (dir_s) begin
						abort = 1'b1;
					end else if (nxt_s) begin
						nxt_r.dout = 8'h00;
						nxt_r.stp = 1'b1;
						nxt_r.st = s_stp;
					end
				end
				s_stp: begin
					nxt_r.stp = 1'b0;
					nxt_r.st = s_idle;
					fin = 1'b1;
				end
				s_rturn: begin
					// Dir rising together with nxt is a packet, not our read data.
					if (dir_s && nxt_s) begin
						abort = 1'b1;
					end else if (dir_s) begin
						nxt_r.st = s_rdata;
					end
				end
				s_rdata: begin
					nxt_r.rdata = din;
					nxt_r.st = s_rend;
				end
				s_rend: begin
					if (!dir_s) begin
						nxt_r.st = s_idle;
						fin = 1'b1;
					end
				end
				s_abort: begin
					nxt_r.oe = 1'b0;
					if (!dir_s) begin
						nxt_r.st = s_idle;
					end
				end
				default: begin
					nxt_r.st = s_idle;
				end
			endcase
		end
		if (abort) begin
			// The request stays pending, so the same access is issued again.
			nxt_r.st = s_abort;
			nxt_r.oe = 1'b0;
			nxt_r.stp = 1'b0;
			nxt_r.retries = r_ff.retries + 8'h01;
			nxt_r.ev[`ULP_EV_ABT] = 1'b1;
		end
		if (fin) begin
			nxt_r.ev[`ULP_EV_DONE] = 1'b1;
			if (r_ff.scr && r_ff.step != last) begin
				nxt_r.step = r_ff.step + 3'h1;
				{nxt_r.addr, nxt_r.wd} = sw;
			end else begin
				nxt_r.req = 1'b0;
				nxt_r.busy = 1'b0;
				nxt_r.scr = 1'b0;
				nxt_r.chirp = r_ff.scr && r_ff.step == `ULP_STEP_RST;
			end
		end
		// Hardware events beat a same-cycle clear so none is lost.
		if (vchg) begin
			nxt_r.ev[`ULP_EV_VB] = 1'b1;
		end
		if (dchg) begin
			nxt_r.ev[`ULP_EV_DC] = 1'b1;
		end
		if (rx_err) begin
			nxt_r.ev[`ULP_EV_DROP] = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_ff <= '0;
		end else if (i_ce) begin
			r_ff <= nxt_r;
		end
	end

	assign o_ulpi_data = r_ff.dout;
	assign o_ulpi_data_oe = r_ff.oe;
	assign o_ulpi_stp = r_ff.stp;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	chk_abort_enter: assert property (
		(i_ce && tick && dir_s && (r_ff.st == s_cmd || r_ff.st == s_wdata))
		|=> r_ff.st == s_abort && r_ff.req && r_ff.retries == $past(r_ff.retries) + 8'h01)
		else $error("unexpected dir did not abort the access");
	chk_abort_resume: assert property (
		(i_ce && tick && !dir_s && r_ff.st == s_abort) |=> r_ff.st == s_idle && r_ff.req)
		else $error("aborted access not queued for retry");
	chk_ext_escape: assert property (
		(r_ff.st == s_cmd && r_ff.oe && r_ff.ext) |-> o_ulpi_data[5:0] == `ULP_EXT_ESC)
		else $error("extended access without escape address");
	chk_script_enables: assert property (
		(r_ff.scr && r_ff.req && (r_ff.step == `ULP_STEP_IER || r_ff.step == `ULP_STEP_IEF)
		&& ulp_role_t'(r_ff.setup[`ULP_SU_ROLE]) == role_host)
		|-> r_ff.wd[`ULP_IE_AVLD] && r_ff.wd[`ULP_IE_DISC])
		else $error("host enables missing supply or disconnect bit");
	chk_fault_config: assert property (
		(r_ff.scr && r_ff.req && r_ff.step == `ULP_STEP_IFC)
		|-> r_ff.addr == `ULP_A_IFC && r_ff.wd[`ULP_IF_PASS] == r_ff.setup[`ULP_SU_FEXT])
		else $error("fault passthrough not matching setup");
	chk_reset_chirp: assert property (
		(r_ff.scr && r_ff.req && r_ff.step == `ULP_STEP_RST)
		|-> r_ff.addr == `ULP_A_FUNC && r_ff.wd == `ULP_FC_CHIRP_RST)
		else $error("reset step wrote wrong function control");
	chk_drop_flag: assert property (
		(i_ce && rx_err) |=> r_ff.ev[`ULP_EV_DROP])
		else $error("receive error did not flag packet drop");
	chk_stp_after_data: assert property (
		$rose(o_ulpi_stp) |-> $past(r_ff.st) == s_wdata && o_ulpi_data == 8'h00)
		else $error("stop raised outside write data phase");
endmodule : ulp_host_link

// >>> verilog/ulp_rxcmd_dec.sv
`include "ulp_params.svh"

module ulp_rxcmd_dec
	import ulp_pkg::*;
	(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_tick,
	input wire logic i_dir,
	input wire logic i_nxt,
	input wire logic [7:0] i_data,
	input wire logic i_own,
	input wire logic i_host,
	input wire logic i_chirp,
	output logic [1:0] o_linestate,
	output logic [1:0] o_vbus,
	output logic o_rx_active,
	output logic o_disc,
	output logic o_alt,
	output logic [1:0] o_speed,
	output logic o_chirp_hs,
	output logic [7:0] o_rx_byte,
	output logic o_rx_valid,
	output logic o_vbus_chg,
	output logic o_disc_chg,
	output logic o_err
	);

	ulp_dec_t r_ff;
	ulp_dec_t nxt_r;

	always_comb begin
		logic [1:0] ev;
		logic [1:0] ls;
		logic disc;
		nxt_r = r_ff;
		ev = i_data[`ULP_RX_EV];
		ls = i_data[`ULP_RX_LS];
		disc = i_host && (ev == `ULP_RXE_DISC);
		nxt_r.bval = 1'b0;
		nxt_r.vchg = 1'b0;
		nxt_r.dchg = 1'b0;
		nxt_r.err = 1'b0;
		if (i_tick) begin
			nxt_r.dir_prev = i_dir;
			if (i_dir && !r_ff.dir_prev && i_nxt && !i_own) begin
				nxt_r.act = 1'b1;
			end else if (!i_dir && r_ff.dir_prev) begin
				// Loss of the bus ends a packet even if no closing command came.
				nxt_r.act = 1'b0;
			end else if (i_dir && r_ff.dir_prev && !i_own) begin
				if (i_nxt) begin
					nxt_r.rx_byte = i_data;
					nxt_r.bval = 1'b1;
				end else begin
					nxt_r.ls = ls;
					nxt_r.vb = i_data[`ULP_RX_VB];
					nxt_r.alt = i_data[`ULP_RX_ALT];
					nxt_r.vchg = i_data[`ULP_RX_VB] != r_ff.vb;
					nxt_r.disc = disc;
					nxt_r.dchg = disc != r_ff.disc;
					if (ev != `ULP_RXE_DISC) begin
						nxt_r.act = (ev == `ULP_RXE_ACT) || (ev == `ULP_RXE_ERR);
					end
					nxt_r.err = ev == `ULP_RXE_ERR;
					if (!i_chirp && !r_ff.act && ls == `ULP_LS_DM) begin
						nxt_r.spd = `ULP_SPD_LS;
					end else if (!i_chirp && !r_ff.act && ls == `ULP_LS_DP) begin
						nxt_r.spd = `ULP_SPD_FS;
					end
					if (i_chirp && ls == `ULP_LS_DP) begin
						nxt_r.hs = 1'b1;
					end else if (i_chirp && ls == `ULP_LS_DM) begin
						nxt_r.hs = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_ff <= '0;
		end else if (i_ce) begin
			r_ff <= nxt_r;
		end
	end

	assign o_linestate = r_ff.ls;
	assign o_vbus = r_ff.vb;
	assign o_rx_active = r_ff.act;
	assign o_disc = r_ff.disc;
	assign o_alt = r_ff.alt;
	assign o_speed = r_ff.spd;
	assign o_chirp_hs = r_ff.hs;
	assign o_rx_byte = r_ff.rx_byte;
	assign o_rx_valid = r_ff.bval;
	assign o_vbus_chg = r_ff.vchg;
	assign o_disc_chg = r_ff.dchg;
	assign o_err = r_ff.err;

	chk_rx_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_tick && i_dir && !r_ff.dir_prev && i_nxt && !i_own) |=> r_ff.act)
		else $error("dir with nxt did not mark receive active");
	chk_rx_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_tick && !i_dir && r_ff.dir_prev) |=> !r_ff.act)
		else $error("receive active survived dir falling");
	chk_speed_class: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_tick && i_dir && r_ff.dir_prev && !i_own && !i_nxt && !i_chirp
		&& !r_ff.act && i_data[`ULP_RX_LS] == `ULP_LS_DM) |=> r_ff.spd == `ULP_SPD_LS)
		else $error("minus line high not classed low speed");
endmodule : ulp_rxcmd_dec

// >>> verilog/ulp_sync.sv
module ulp_sync
	import ulp_pkg::*;
	#(parameter int unsigned W = 11)
	(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
	);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ulp_sync_t;

	ulp_sync_t r_ff;
	ulp_sync_t nxt_r;

	always_comb begin
		nxt_r.s1 = i_d;
		nxt_r.s2 = r_ff.s1;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_ff <= '0;
		end else if (i_ce) begin
			r_ff <= nxt_r;
		end
	end

	assign o_q = r_ff.s2;
endmodule : ulp_sync
